/* File: rtl/tmr2_timer.sv */
// Purpose: 16-bit timer/counter two with capture, auto-reload and baud modes
// Assumes: i_count_pin and i_external_trigger_input synchronous to i_clk_sys
// Notes:   register port answers reads one cycle later; no wait states
`include "tmr2_defines.svh"

//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - select bit 0 counts the clock divided by six, 1 counts count-pin falling edges.
// - capture mode without external enable is a plain 16-bit counter setting overflow.
// - in capture mode with external enable a trigger fall copies count to capture bytes.
// - such a capture also sets the external flag.
// - in auto-reload mode rollover sets overflow and loads count from the reload pair.
// - in auto-reload with external enable a trigger fall reloads and sets external flag.
// - either baud select bit set enters baud mode whatever the capture/reload bit is.
// - baud mode forces auto-reload on each overflow.
// - with either baud select bit set the overflow flag is not set.
// - hardware only sets the two flags; software clears them by writing zero.
// - with interrupt enabled either flag raises the timer two interrupt.
// - receive select set gives our overflow pulses as receive clock, else timer one.
// - transmit select set gives our overflow pulses as transmit clock, else timer one.
// - with baud bits clear and run set, capture bit 0 is reload and 1 is capture.
module tmr2_timer (
    input  wire logic       i_clk_sys,
    input  wire logic       i_nrst,
    input  wire logic [2:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic       i_count_pin,
    input  wire logic       i_external_trigger_input,
    input  wire logic       i_timer1_ovf,
    output logic      [7:0] o_rdata,
    output logic            o_irq,
    output logic            o_timer2_irq,
    output logic            o_rx_baud_clk,
    output logic            o_tx_baud_clk,
    output tmr2_pkg::tmr2_ctrl_t o_ctrl
);
    import tmr2_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // reset release
    logic                   rst_meta_ff;
    logic                   rst_n_ff;

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // declarations
    tmr2_ctrl_t             ctrl_ff;
    logic [15:0]            cnt_ff;
    logic [15:0]            cap_ff;
    logic [`TMR2_PRE_W-1:0] pre_ff;
    logic [`TMR2_EV_N-1:0]  stat_ff;
    logic [`TMR2_EV_N-1:0]  mask_ff;
    logic                   ie_ff;
    logic                   cnt_fall;
    logic                   trig_fall;
    logic                   baud_mode;
    logic                   tick;
    logic                   ovf;
    logic                   ext_ev;
    logic                   wr_ctrl;
    logic                   wr_cnt_lo;
    logic                   wr_cnt_hi;
    logic                   wr_cap_lo;
    logic                   wr_cap_hi;
    logic                   wr_mask;
    logic                   wr_ie;
    logic                   rd_stat;
    logic                   ev_ovf_flag;
    logic                   ev_cap;
    logic [`TMR2_EV_N-1:0]  ev_vec;
    logic                   rx_pulse;
    logic                   tx_pulse;
    logic                   irq_lvl;
    logic                   t2_irq_lvl;
    tmr2_req_t              bus_req;
    tmr2_mode_t             mode;
    tmr2_ctrl_t             wctrl;
    logic [15:0]            nxt_cnt;
    logic [7:0]             nxt_rdata;

    //////////////////////////////////////////////////////////////////////////
    // register port decode
    // one strobe per register; reads and writes never overlap
    assign bus_req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    assign wctrl     = tmr2_ctrl_t'(bus_req.wdata);
    assign wr_ctrl   = bus_req.wr && (bus_req.addr == `TMR2_OFF_CTRL);
    assign wr_cnt_lo = bus_req.wr && (bus_req.addr == `TMR2_OFF_CNT_LO);
    assign wr_cnt_hi = bus_req.wr && (bus_req.addr == `TMR2_OFF_CNT_HI);
    assign wr_cap_lo = bus_req.wr && (bus_req.addr == `TMR2_OFF_CAP_LO);
    assign wr_cap_hi = bus_req.wr && (bus_req.addr == `TMR2_OFF_CAP_HI);
    assign wr_mask   = bus_req.wr && (bus_req.addr == `TMR2_OFF_IRQ_MASK);
    assign wr_ie     = bus_req.wr && (bus_req.addr == `TMR2_OFF_IE);
    assign rd_stat   = bus_req.rd && (bus_req.addr == `TMR2_OFF_IRQ_STAT);

    tmr2_fall_det u_cnt_fall (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (rst_n_ff),
        .i_level   (i_count_pin),
        .o_fall    (cnt_fall)
    );

    tmr2_fall_det u_trig_fall (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (rst_n_ff),
        .i_level   (i_external_trigger_input),
        .o_fall    (trig_fall)
    );

    //////////////////////////////////////////////////////////////////////////
    // mode decode
    assign baud_mode = ctrl_ff.rx_baud_select | ctrl_ff.tx_baud_select;

    always_comb begin
        if (!ctrl_ff.run_control) begin
            mode = TMR2_OFF;
        end else if (baud_mode || !ctrl_ff.capture_reload_select) begin
            mode = TMR2_RELOAD;
        end else begin
            mode = TMR2_CAPTURE;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // prescaler: one tick every six clocks
    always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            pre_ff <= '0;
        end else if (!ctrl_ff.run_control || ctrl_ff.timer_counter_select) begin
            pre_ff <= '0;
        end else if (pre_ff == `TMR2_PRE_LAST) begin
            pre_ff <= '0;
        end else begin
            pre_ff <= pre_ff + `TMR2_PRE_W'(1);
        end
    end

    always_comb begin
        if (ctrl_ff.timer_counter_select) begin
            tick = cnt_fall;
        end else begin
            tick = (pre_ff == `TMR2_PRE_LAST);
        end
    end

    assign ovf    = (mode != TMR2_OFF) && tick && (cnt_ff == `TMR2_CNT_MAX);
    assign ext_ev = (mode != TMR2_OFF) && ctrl_ff.external_trigger_enable && trig_fall
                    && !baud_mode;

    // flag events; baud mode never raises the overflow flag
    assign ev_ovf_flag = ovf && !baud_mode;
    assign ev_cap      = ext_ev && (mode == TMR2_CAPTURE);

    always_comb begin
        ev_vec               = '0;
        ev_vec[`TMR2_EV_OVF] = ev_ovf_flag;
        ev_vec[`TMR2_EV_EXF] = ext_ev;
        ev_vec[`TMR2_EV_CAP] = ev_cap;
    end

    //////////////////////////////////////////////////////////////////////////
    // counter
    always_comb begin
        nxt_cnt = cnt_ff;
        case (mode)
            TMR2_OFF: begin
                nxt_cnt = cnt_ff;
            end
            TMR2_CAPTURE: begin
                if (tick) begin
                    nxt_cnt = cnt_ff + 16'h0001;
                end
            end
            TMR2_RELOAD: begin
                if (ovf || ext_ev) begin
                    nxt_cnt = cap_ff;
                end else if (tick) begin
                    nxt_cnt = cnt_ff + 16'h0001;
                end
            end
            default: begin
                nxt_cnt = cnt_ff;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            cnt_ff <= `TMR2_CNT_RST;
        end else if (wr_cnt_lo) begin
            // a software write to the count wins over counting
            cnt_ff <= {cnt_ff[15:8], bus_req.wdata};
        end else if (wr_cnt_hi) begin
            cnt_ff <= {bus_req.wdata, cnt_ff[7:0]};
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // capture / reload pair
    always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            cap_ff <= `TMR2_CNT_RST;
        end else if (ev_cap) begin
            // a trigger capture wins over a software write to the pair
            cap_ff <= cnt_ff;
        end else if (wr_cap_lo) begin
            cap_ff <= {cap_ff[15:8], bus_req.wdata};
        end else if (wr_cap_hi) begin
            cap_ff <= {bus_req.wdata, cap_ff[7:0]};
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // control register and flags; hardware set beats software clear
    always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            ctrl_ff <= tmr2_ctrl_t'(`TMR2_CTRL_RST);
        end else begin
            if (wr_ctrl) begin
                ctrl_ff.rx_baud_select          <= wctrl.rx_baud_select;
                ctrl_ff.tx_baud_select          <= wctrl.tx_baud_select;
                ctrl_ff.external_trigger_enable <= wctrl.external_trigger_enable;
                ctrl_ff.run_control             <= wctrl.run_control;
                ctrl_ff.timer_counter_select    <= wctrl.timer_counter_select;
                ctrl_ff.capture_reload_select   <= wctrl.capture_reload_select;
            end
            if (ev_ovf_flag) begin
                ctrl_ff.overflow_flag <= 1'b1;
            end else if (wr_ctrl && !wctrl.overflow_flag) begin
                ctrl_ff.overflow_flag <= 1'b0;
            end
            if (ext_ev) begin
                ctrl_ff.external_trigger_flag <= 1'b1;
            end else if (wr_ctrl && !wctrl.external_trigger_flag) begin
                ctrl_ff.external_trigger_flag <= 1'b0;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // interrupt status, mask, enable
    always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            stat_ff <= '0;
        end else begin
            // sticky until a status read; an event in the read cycle wins
            for (int i = 0; i < `TMR2_EV_N; i++) begin
                if (ev_vec[i]) begin
                    stat_ff[i] <= 1'b1;
                end else if (rd_stat) begin
                    stat_ff[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            mask_ff <= '0;
        end else if (wr_mask) begin
            mask_ff <= bus_req.wdata[`TMR2_EV_N-1:0];
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            ie_ff <= 1'b0;
        end else if (wr_ie) begin
            ie_ff <= bus_req.wdata[0];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // read mux
    always_comb begin
        case (i_addr)
            `TMR2_OFF_CTRL:     nxt_rdata = ctrl_ff;
            `TMR2_OFF_CNT_LO:   nxt_rdata = cnt_ff[7:0];
            `TMR2_OFF_CNT_HI:   nxt_rdata = cnt_ff[15:8];
            `TMR2_OFF_CAP_LO:   nxt_rdata = cap_ff[7:0];
            `TMR2_OFF_CAP_HI:   nxt_rdata = cap_ff[15:8];
            `TMR2_OFF_IRQ_STAT: nxt_rdata = {5'h00, stat_ff};
            `TMR2_OFF_IRQ_MASK: nxt_rdata = {5'h00, mask_ff};
            `TMR2_OFF_IE:       nxt_rdata = {7'h00, ie_ff};
            default:            nxt_rdata = 8'h00;
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // baud clock selection and interrupt levels
    always_comb begin
        if (ctrl_ff.rx_baud_select) begin
            rx_pulse = ovf;
        end else begin
            rx_pulse = i_timer1_ovf;
        end
    end

    always_comb begin
        if (ctrl_ff.tx_baud_select) begin
            tx_pulse = ovf;
        end else begin
            tx_pulse = i_timer1_ovf;
        end
    end

    assign irq_lvl    = |(stat_ff & mask_ff);
    assign t2_irq_lvl = ie_ff
                        && (ctrl_ff.overflow_flag || ctrl_ff.external_trigger_flag);

    //////////////////////////////////////////////////////////////////////////
    // registered outputs
    always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            o_rdata       <= 8'h00;
            o_irq         <= 1'b0;
            o_timer2_irq  <= 1'b0;
            o_rx_baud_clk <= 1'b0;
            o_tx_baud_clk <= 1'b0;
            o_ctrl        <= tmr2_ctrl_t'(`TMR2_CTRL_RST);
        end else begin
            o_rdata       <= i_rd ? nxt_rdata : 8'h00;
            o_irq         <= irq_lvl;
            o_timer2_irq  <= t2_irq_lvl;
            o_rx_baud_clk <= rx_pulse;
            o_tx_baud_clk <= tx_pulse;
            o_ctrl        <= ctrl_ff;
        end
    end
endmodule : tmr2_timer

/* File: rtl/tmr2_defines.svh */
// Purpose: constants for the timer two block
// Assumes: byte-wide register port, word index addressing
// Notes:   offsets are register indices on the local port
`ifndef TMR2_DEFINES_SVH
`define TMR2_DEFINES_SVH

`define TMR2_ADDR_W          3
`define TMR2_OFF_CTRL        3'h0
`define TMR2_OFF_CNT_LO      3'h1
`define TMR2_OFF_CNT_HI      3'h2
`define TMR2_OFF_CAP_LO      3'h3
`define TMR2_OFF_CAP_HI      3'h4
`define TMR2_OFF_IRQ_STAT    3'h5
`define TMR2_OFF_IRQ_MASK    3'h6
`define TMR2_OFF_IE          3'h7

`define TMR2_BIT_OVF         7
`define TMR2_BIT_EXF         6
`define TMR2_BIT_RXSEL       5
`define TMR2_BIT_TXSEL       4
`define TMR2_BIT_EXEN        3
`define TMR2_BIT_RUN         2
`define TMR2_BIT_CT          1
`define TMR2_BIT_CPRL        0

`define TMR2_CTRL_RST        8'h00
`define TMR2_CNT_RST         16'h0000
`define TMR2_CNT_MAX         16'hFFFF
`define TMR2_PRESCALE_DIV    6
`define TMR2_PRE_W           3
`define TMR2_PRE_LAST        3'h5

`define TMR2_EV_OVF          0
`define TMR2_EV_EXF          1
`define TMR2_EV_CAP          2
`define TMR2_EV_N            3

`endif

/* File: rtl/tmr2_pkg.sv */
// Purpose: types for the timer two block
// Assumes: constants live in tmr2_defines.svh
// Notes:   control layout matches the control register bit order
package tmr2_pkg;

    typedef struct packed {
        logic       overflow_flag;
        logic       external_trigger_flag;
        logic       rx_baud_select;
        logic       tx_baud_select;
        logic       external_trigger_enable;
        logic       run_control;
        logic       timer_counter_select;
        logic       capture_reload_select;
    } tmr2_ctrl_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tmr2_req_t;

    typedef enum logic [2:0] {
        TMR2_OFF     = 3'b001,
        TMR2_CAPTURE = 3'b010,
        TMR2_RELOAD  = 3'b100
    } tmr2_mode_t;

endpackage : tmr2_pkg

/* File: rtl/tmr2_fall_det.sv */
// Purpose: falling edge detector for one synchronous input
// Assumes: input already synchronous to the clock
// Notes:   pulse lasts one cycle after the high-to-low step
module tmr2_fall_det (
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    input  wire logic i_level,
    output logic      o_fall
);
    logic prev_ff;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_ff <= 1'b1;
        end else begin
            prev_ff <= i_level;
        end
    end

    assign o_fall = prev_ff & ~i_level;
endmodule : tmr2_fall_det

/* File: dv/tmr2_src_model.sv */
// Purpose: far-side source of count pin and trigger falls
// Assumes: requests at least five clocks apart
// Notes:   each request pulls its line low for two clocks
module tmr2_src_model (
    input  wire logic i_clk_sys,
    input  wire logic i_cnt_req,
    input  wire logic i_trg_req,
    output logic      o_count_pin,
    output logic      o_trig
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] cnt_sh = 2'h0;
    logic [1:0] trg_sh = 2'h0;
    always @(posedge i_clk_sys) begin
        cnt_sh <= {cnt_sh[0], i_cnt_req};
        trg_sh <= {trg_sh[0], i_trg_req};
    end
    assign o_count_pin = !(|cnt_sh);
    assign o_trig      = !(|trg_sh);
endmodule : tmr2_src_model

/* File: dv/tmr2_timer_checker.sv */
// Purpose: port checker for the timer two block
// Assumes: sees only top ports
// Notes:   o_ctrl and registered outputs share one cycle of lag
module tmr2_timer_checker (
    input wire logic                 i_clk_sys,
    input wire logic                 i_nrst,
    input wire logic [2:0]           i_addr,
    input wire logic                 i_rd,
    input wire logic                 i_wr,
    input wire logic                 i_external_trigger_input,
    input wire logic                 i_timer1_ovf,
    input wire logic [7:0]           o_rdata,
    input wire logic                 o_timer2_irq,
    input wire logic                 o_rx_baud_clk,
    input wire logic                 o_tx_baud_clk,
    input wire tmr2_pkg::tmr2_ctrl_t o_ctrl
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    AST_RD_CTRL: assert property ($past(i_rd) && $past(i_addr) == 3'h0 |-> o_rdata == o_ctrl)
        else $error("control read data wrong");
    AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not zero");
    AST_SW_CLEAR: assert property ($fell(o_ctrl.overflow_flag) || $fell(o_ctrl.external_trigger_flag)
        |-> $past(i_wr, 2) && $past(i_addr, 2) == 3'h0) else $error("flag cleared by hardware");
    AST_NO_OVF_BAUD: assert property ($rose(o_ctrl.overflow_flag)
        |-> !$past(o_ctrl.rx_baud_select) && !$past(o_ctrl.tx_baud_select)) else $error("flag in baud");
    AST_RX_T1: assert property (!o_ctrl.rx_baud_select |-> o_rx_baud_clk == $past(i_timer1_ovf))
        else $error("receive clock not timer one");
    AST_TX_T1: assert property (!o_ctrl.tx_baud_select |-> o_tx_baud_clk == $past(i_timer1_ovf))
        else $error("transmit clock not timer one");
    AST_STOPPED: assert property (o_ctrl.rx_baud_select && !o_ctrl.run_control |-> !o_rx_baud_clk)
        else $error("pulse while stopped");
    AST_EXF_SET: assert property ($fell(i_external_trigger_input) && o_ctrl.external_trigger_enable
        && !o_ctrl.rx_baud_select && !o_ctrl.tx_baud_select |-> ##[1:4] o_ctrl.external_trigger_flag)
        else $error("external flag not set");
    AST_IRQ_SRC: assert property (o_timer2_irq |-> o_ctrl.overflow_flag || o_ctrl.external_trigger_flag)
        else $error("interrupt without flag");
    cover property (o_rx_baud_clk && o_ctrl.rx_baud_select);
    cover property (o_ctrl.external_trigger_flag);
    cover property (o_timer2_irq);
endmodule : tmr2_timer_checker
bind tmr2_timer tmr2_timer_checker chk_u (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_addr(i_addr),
    .i_rd(i_rd), .i_wr(i_wr), .i_external_trigger_input(i_external_trigger_input),
    .i_timer1_ovf(i_timer1_ovf), .o_rdata(o_rdata), .o_timer2_irq(o_timer2_irq),
    .o_rx_baud_clk(o_rx_baud_clk), .o_tx_baud_clk(o_tx_baud_clk), .o_ctrl(o_ctrl));

/* File: dv/tmr2_timer_bench.sv */
// Purpose: self-checking bench for the timer two block
// Assumes: src model makes the pin falls
// Notes:   seeded random starts and reload values
`include "tmr2_defines.svh"
module tmr2_timer_bench;
    import tmr2_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk = 0, nrst = 0, wr = 0, rd_s = 0, cnt_req = 0, trg_req = 0, t1 = 0;
    logic [2:0] addr = 0;
    logic [7:0] wdata = 0, rdata, d;
    logic       pin, trig, irq, t2irq, rxb, txb, ovf;
    tmr2_ctrl_t ctrl;
    logic [15:0] c, rl, v;
    logic [7:0] nov_sel [3] = '{8'h20, 8'h10, 8'h30};
    int         err_count = 0, compares = 0, seed = 18, rxn = 0, txn = 0, n, nov;
    always #25 clk = ~clk;
    always @(posedge clk) begin
        rxn += rxb;
        txn += txb;
    end
    tmr2_src_model src_u (.i_clk_sys(clk), .i_cnt_req(cnt_req), .i_trg_req(trg_req),
        .o_count_pin(pin), .o_trig(trig));
    tmr2_timer dut_u (.i_clk_sys(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd_s), .i_count_pin(pin), .i_external_trigger_input(trig), .i_timer1_ovf(t1),
        .o_rdata(rdata), .o_irq(irq), .o_timer2_irq(t2irq), .o_rx_baud_clk(rxb),
        .o_tx_baud_clk(txb), .o_ctrl(ctrl));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic wrb(input logic [2:0] a, input logic [7:0] x);
        @(posedge clk);
        addr <= a;
        wdata <= x;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wrb
    task automatic rdb(input logic [2:0] a, output logic [7:0] x);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 x = rdata;
    endtask : rdb
    task automatic wr16(input logic [2:0] a, input logic [15:0] x);
        wrb(a, x[7:0]);
        wrb(a + 3'h1, x[15:8]);
    endtask : wr16
    task automatic rd16(input logic [2:0] a, output logic [15:0] x);
        logic [7:0] lo;
        rdb(a, lo);
        rdb(a + 3'h1, x[15:8]);
        x[7:0] = lo;
    endtask : rd16
    // falls on the count pin (t=0) or the trigger (t=1)
    task automatic src(input logic t, input int k);
        repeat (k) begin
            @(posedge clk);
            if (t) trg_req <= 1'b1;
            else cnt_req <= 1'b1;
            @(posedge clk);
            trg_req <= 1'b0;
            cnt_req <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask : src
    function automatic logic [15:0] step(input logic [15:0] x, input logic [15:0] r, input logic re);
        step = (x == 16'hFFFF) ? (re ? r : 16'h0000) : x + 16'h0001;
    endfunction : step
    // run c through k falls, counting overflows in nov
    task automatic predict(input int k, input logic re);
        nov = 0;
        repeat (k) begin
            nov += (c == 16'hFFFF);
            c = step(c, rl, re);
        end
    endtask : predict
    task automatic tally_and_finish;
        if (err_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #1_000_000 err_count++;
        tally_and_finish();
    end
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        rdb(`TMR2_OFF_CTRL, d);
        chk("ctrl_reset", 16'h0000, {8'h00, d});
        wr16(`TMR2_OFF_CNT_LO, 16'h0000);
        wrb(`TMR2_OFF_CTRL, 8'h04);
        repeat (31) @(posedge clk);
        wrb(`TMR2_OFF_CTRL, 8'h00);
        rd16(`TMR2_OFF_CNT_LO, v);
        chk("timer_ticks", 16'h0005, v);
        wrb(`TMR2_OFF_IE, 8'h01);
        wrb(`TMR2_OFF_IRQ_MASK, 8'h01);
        for (int i = 0; i < 8; i++) begin
            c = 16'hFFF8 | 16'($random(seed) & 7);
            rl = 16'($random(seed));
            n = 1 + ($random(seed) & 15);
            wr16(`TMR2_OFF_CAP_LO, rl);
            wr16(`TMR2_OFF_CNT_LO, c);
            wrb(`TMR2_OFF_CTRL, 8'h06 | 8'(i[0]));
            src(1'b0, n);
            predict(n, !i[0]);
            ovf = (nov != 0);
            rd16(`TMR2_OFF_CNT_LO, v);
            chk("count", c, v);
            rdb(`TMR2_OFF_CTRL, d);
            chk("ovf_flag", 16'(ovf), 16'(d[7]));
            chk("t2_irq", 16'(ovf), 16'(t2irq));
            chk("irq", 16'(ovf), 16'(irq));
            rdb(`TMR2_OFF_IRQ_STAT, d);
            chk("stat", 16'(ovf), 16'(d));
            rdb(`TMR2_OFF_IRQ_STAT, d);
            chk("stat_clr", 16'h0000, 16'(d));
            wrb(`TMR2_OFF_CTRL, 8'h00);
            rdb(`TMR2_OFF_CTRL, d);
            chk("flag_clr", 16'h0000, 16'(d));
        end
        c = 16'($random(seed));
        wr16(`TMR2_OFF_CNT_LO, c);
        wrb(`TMR2_OFF_CTRL, 8'h0F);
        src(1'b1, 1);
        rd16(`TMR2_OFF_CAP_LO, v);
        chk("capture", c, v);
        rdb(`TMR2_OFF_CTRL, d);
        chk("cap_ctrl", 16'h004F, 16'(d));
        chk("t2_irq_ext", 16'h0001, 16'(t2irq));
        chk("irq_masked", 16'h0000, 16'(irq));
        rdb(`TMR2_OFF_IRQ_STAT, d);
        chk("cap_stat", 16'h0006, 16'(d));
        wrb(`TMR2_OFF_CTRL, 8'h0E);
        wr16(`TMR2_OFF_CNT_LO, ~c);
        src(1'b1, 1);
        rd16(`TMR2_OFF_CNT_LO, v);
        chk("trig_reload", c, v);
        rdb(`TMR2_OFF_CTRL, d);
        chk("rl_ctrl", 16'h004E, 16'(d));
        rdb(`TMR2_OFF_IRQ_STAT, d);
        chk("rl_stat", 16'h0002, 16'(d));
        foreach (nov_sel[j]) begin
            wrb(`TMR2_OFF_CTRL, nov_sel[j]);
            c = 16'hFFFE;
            rl = 16'($random(seed));
            wr16(`TMR2_OFF_CAP_LO, rl);
            wr16(`TMR2_OFF_CNT_LO, c);
            rxn = 0;
            txn = 0;
            wrb(`TMR2_OFF_CTRL, nov_sel[j] | 8'h07);
            @(posedge clk) t1 <= 1'b1;
            @(posedge clk) t1 <= 1'b0;
            src(1'b0, 3);
            predict(3, 1'b1);
            rd16(`TMR2_OFF_CNT_LO, v);
            chk("baud_count", c, v);
            rdb(`TMR2_OFF_CTRL, d);
            chk("baud_ctrl", 16'(nov_sel[j] | 8'h07), 16'(d));
            chk("rx_pulses", nov_sel[j][5] ? 16'(nov) : 16'h0001, 16'(rxn));
            chk("tx_pulses", nov_sel[j][4] ? 16'(nov) : 16'h0001, 16'(txn));
        end
        tally_and_finish();
    end
endmodule : tmr2_timer_bench
